// File: tb_ubgrf_top.sv
// Self-checking bench for the baud generator and receive filter
`timescale 1ns/1ps
`default_nettype none
module tb_ubgrf_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic send = 1'b0;
  logic dip = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] reg_rdata;
  logic pin, tx_bit_tick, rx_sample_tick, rx_start_detected, rx_filtered, pb, pc, pf;
  logic [15:0] cfg [4] = '{16'h0004, 16'h0105, 16'h02FF, 16'h0A04};
  int bad_count = 0;
  int comparisons = 0;
  int starts = 0;
  int lows = 0;
  int n, s0, l0;
  always #5 clk_sys = ~clk_sys;
  always #40 ext_clk = ~ext_clk;
  always @(posedge clk_sys) begin
    starts <= starts + int'(rx_start_detected === 1'b1);
    lows <= lows + int'(rx_filtered === 1'b0);
  end
  ubgrf_top i_dut (.clk_sys, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_receive_pin(pin), .external_baud_clock_pin(ext_clk), .tx_bit_tick, .rx_sample_tick,
    .rx_start_detected, .rx_filtered, .parity_bit_present(pb), .parity_check_enable(pc), .parity_tx_force_low(pf));
  ubgrf_serial_peer i_peer (.clk_sys, .send, .data(8'hFF), .bit_len(16'h0008), .dip, .line(pin));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("rdata", reg_rdata, e);
  endtask : rd
  // Power off before touching the clock select and divisor
  task automatic setup(input logic [7:0] cks, input logic [7:0] div, input logic [7:0] ctl);
    wr(ubgrf_pkg::ADDR_CONTROL0, 8'h00);
    wr(ubgrf_pkg::ADDR_CLK_SELECT, cks);
    wr(ubgrf_pkg::ADDR_DIVISOR, div);
    wr(ubgrf_pkg::ADDR_CONTROL0, ctl);
  endtask : setup
  task automatic gap(input logic rx);
    n = 1;
    @(negedge clk_sys);
    while ((rx ? rx_sample_tick : tx_bit_tick) !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      bad_count++;
      test_done();
    end
  endtask : gap
  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ubgrf_pkg::ADDR_DIVISOR, 8'hFF);
    rd(ubgrf_pkg::ADDR_CLK_SELECT, 8'h00);
    rd(8'h7F, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ubgrf_pkg::ADDR_CONTROL0, {4'h0, 2'(m), 2'h0});
      repeat (3) @(negedge clk_sys);
      chk("parity", {pb, pc, pf}, {m != 0, m > 1, m == 1});
    end
    setup(8'h00, 8'h04, 8'h60);
    n = 0;
    repeat (300) begin
      @(negedge clk_sys);
      n += int'(tx_bit_tick !== 1'b0 || rx_sample_tick !== 1'b0);
    end
    chk("gated ticks", n, 0);
    foreach (cfg[i]) begin
      setup(cfg[i][15:8], cfg[i][7:0], 8'hE0);
      gap(1'b0);
      gap(1'b0);
      chk("tx period", n, 32'(cfg[i][7:0]) << (cfg[i][15:8] + 8'h01));
    end
    setup({4'h0, ubgrf_pkg::CKS_EXTERNAL}, 8'h04, 8'hE0);
    gap(1'b0);
    gap(1'b0);
    chk("ext period", n, 64);
    setup(8'h00, 8'h04, 8'hA0);
    s0 = starts;
    l0 = lows;
    @(posedge clk_sys);
    dip <= 1'b1;
    repeat (2) @(posedge clk_sys);
    dip <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("glitch", lows - l0 + starts - s0, 0);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    gap(1'b1);
    gap(1'b1);
    chk("rx period", n, 8);
    repeat (100) @(posedge clk_sys);
    chk("starts", starts - s0, 1);
    test_done();
  end
endmodule : tb_ubgrf_top
`default_nettype wire

// File: ubgrf_noise_filter.sv
// Receive pin noise filter sampled on the base clock tick
`timescale 1ns/1ps
`default_nettype none
module ubgrf_noise_filter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Sample tick and raw pin
  input wire logic tick,
  input wire logic pin_in,
  // Filtered level
  output logic filt_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } ubgrf_nf_state_type;

  ubgrf_nf_state_type st_reg;
  ubgrf_nf_state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (tick) begin
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // Output follows only when the held samples agree, so two-tick pulses drop
      if (st_reg.s1 == st_reg.s2 && st_reg.s2 == st_reg.s3) begin
        st_next.filt = st_reg.s3;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, filt: 1'b1};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign filt_out = st_reg.filt;
endmodule : ubgrf_noise_filter
`default_nettype wire

// File: ubgrf_pkg.sv
// Package: register map, field layout, reset values and codes for the baud generator and receive filter
package ubgrf_pkg;
  // ****************************************************************
  // Register indices (byte address = 4 * index)
  // ****************************************************************
  localparam logic [27:0] BAUD_DIVISOR_CH0_IDX = 28'hFFFFA02;
  localparam logic [31:0] BAUD_DIVISOR_CH1_IDX = 32'hFFFFFA12;
  localparam logic [31:0] BAUD_DIVISOR_CH2_IDX = 32'hFFFFFA22;
  localparam logic [31:0] BAUD_DIVISOR_CH3_IDX = 32'hFFFFFA32;
  localparam logic [7:0] ADDR_DIVISOR = 8'h02;
  localparam logic [7:0] ADDR_CLK_SELECT = 8'h01;
  localparam logic [7:0] ADDR_CONTROL0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  // ****************************************************************
  // Reset values and fields
  // ****************************************************************
  localparam logic [7:0] CLK_SELECT_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hFF;
  localparam logic [7:0] CONTROL0_RESET = 8'h00;
  localparam int CTL0_POWER_BIT = 7;
  localparam int CTL0_TX_ENABLE_BIT = 6;
  localparam int CTL0_RX_ENABLE_BIT = 5;
  localparam int CTL0_PARITY_HI = 3;
  localparam int CTL0_PARITY_LO = 2;
  localparam int CKS_HI = 3;
  localparam logic [3:0] CKS_MAX_INTERNAL = 4'hA;
  localparam logic [3:0] CKS_EXTERNAL = 4'hB;
  localparam logic [7:0] DIVISOR_MIN = 8'h04;
  // Sample points after the start bit: eight data bits and the stop bit
  localparam logic [3:0] FRAME_TAIL_SAMPLES = 4'h9;
  // Parity modes
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ZERO = 2'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic [1:0] PARITY_EVEN = 2'h3;
endpackage : ubgrf_pkg

// File: ubgrf_serial_peer.sv
// Remote serial peer driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module ubgrf_serial_peer (
  // Clock and request
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic [15:0] bit_len,
  input wire logic dip,
  // Line toward the device
  output logic line
);
  // ******
  // Frame shifter, idle high, start low, LSB first
  // ******
  logic [9:0] frame_reg = 10'h3FF;
  logic [15:0] cnt_reg = 16'h0000;
  assign line = frame_reg[0] & ~dip;
  always @(posedge clk_sys) begin
    if (send && frame_reg == 10'h3FF) begin
      frame_reg <= {1'b1, data, 1'b0};
      cnt_reg <= bit_len - 16'h0001;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end else if (frame_reg != 10'h3FF) begin
      frame_reg <= {1'b1, frame_reg[9:1]};
      cnt_reg <= bit_len - 16'h0001;
    end
  end
endmodule : ubgrf_serial_peer
`default_nettype wire

// File: ubgrf_top.sv
// Baud generator with base clock prescaler, divider counters and receive filter
`timescale 1ns/1ps
`default_nettype none
// Contract
// - zero parity sends parity bit low
// - zero parity never checks received parity
// - no parity omits bit, never errors
// - filter samples on base clock, three agree
// - pulses of two periods are noise
// - receive path lags pin three base clocks
// - base clock only while power bit set
// - independent 8-bit transmit and receive dividers
// - select main clock divided 2^m or pin (pin only when IS_CHANNEL0 is set)
// - divisor k from 4 to 255
// - bit period is 2k base clocks
// - internal rate main over 2^(m+1)k
// - start bit needs edge then low sample
// - receive counter starts on the falling start edge, before the low sample
module ubgrf_top #(
  parameter bit IS_CHANNEL0 = 1'b1
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic serial_receive_pin,
  input wire logic external_baud_clock_pin,
  // Serial clocks, receive conditioning and parity decode outputs
  output logic tx_bit_tick,
  output logic rx_sample_tick,
  output logic rx_start_detected,
  output logic rx_filtered,
  output logic parity_bit_present,
  output logic parity_check_enable,
  output logic parity_tx_force_low
);
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] cks;
    logic [7:0] divisor;
    logic [7:0] rdata;
    logic [9:0] prescale;
    logic ext1;
    logic ext2;
    logic ext3;
    logic [7:0] tx_cnt;
    logic tx_half;
    logic [7:0] rx_cnt;
    logic rx_half;
    logic rx_busy;
    logic rx_seen_high;
    logic rx_verify;
    logic [3:0] rx_bits;
    logic rx_prev;
    logic tx_tick;
    logic rx_tick;
    logic start_det;
    logic rx_filt;
    logic par_present;
    logic par_check;
    logic par_low;
  } ubgrf_state_type;

  ubgrf_state_type st_reg;
  ubgrf_state_type st_next;
  logic base_tick;
  logic filt_level;
  logic power_on;
  logic tx_on;
  logic rx_on;
  logic [1:0] parity_mode;
  logic [9:0] pre_inc;
  logic [3:0] cks_code;
  logic [9:0] pre_mask;
  logic [3:0] frame_len;

  // ****************************************************************
  // Base clock selection
  // ****************************************************************
  assign power_on = st_reg.ctl0[ubgrf_pkg::CTL0_POWER_BIT];
  assign tx_on = st_reg.ctl0[ubgrf_pkg::CTL0_TX_ENABLE_BIT];
  assign rx_on = st_reg.ctl0[ubgrf_pkg::CTL0_RX_ENABLE_BIT];
  assign parity_mode = st_reg.ctl0[ubgrf_pkg::CTL0_PARITY_HI:ubgrf_pkg::CTL0_PARITY_LO];
  assign cks_code = st_reg.cks[ubgrf_pkg::CKS_HI:0];
  assign pre_inc = st_reg.prescale + 10'h001;
  assign pre_mask = (10'h001 << cks_code) - 10'h001;
  assign frame_len = ubgrf_pkg::FRAME_TAIL_SAMPLES + {3'h0, st_reg.par_present};

  always_comb begin
    base_tick = 1'b0;
    if (power_on) begin
      if (cks_code == 4'h0) begin
        base_tick = 1'b1;
      end else if (cks_code <= ubgrf_pkg::CKS_MAX_INTERNAL) begin
        // Tick when the low m bits of the prescaler wrap: main clock / 2^m
        base_tick = (st_reg.prescale & pre_mask) == pre_mask;
      end else if (cks_code == ubgrf_pkg::CKS_EXTERNAL && IS_CHANNEL0) begin
        // Rising edge of the synchronised external clock
        base_tick = st_reg.ext2 && !st_reg.ext3;
      end
    end
  end

  ubgrf_noise_filter u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .tick(base_tick),
    .pin_in(serial_receive_pin),
    .filt_out(filt_level)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.tx_tick = 1'b0;
    st_next.rx_tick = 1'b0;
    st_next.start_det = 1'b0;
    st_next.rx_filt = filt_level;
    st_next.ext1 = external_baud_clock_pin;
    st_next.ext2 = st_reg.ext1;
    st_next.ext3 = st_reg.ext2;
    st_next.prescale = power_on ? pre_inc : 10'h000;
    // Parity decode
    st_next.par_present = (parity_mode != ubgrf_pkg::PARITY_NONE);
    st_next.par_check = (parity_mode == ubgrf_pkg::PARITY_ODD) || (parity_mode == ubgrf_pkg::PARITY_EVEN);
    st_next.par_low = (parity_mode == ubgrf_pkg::PARITY_ZERO);

    // Register port
    st_next.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        ubgrf_pkg::ADDR_CONTROL0: st_next.ctl0 = reg_wdata;
        ubgrf_pkg::ADDR_CLK_SELECT: st_next.cks = reg_wdata;
        ubgrf_pkg::ADDR_DIVISOR: st_next.divisor = reg_wdata;
        default: st_next.ctl0 = st_reg.ctl0;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ubgrf_pkg::ADDR_CONTROL0: st_next.rdata = st_reg.ctl0;
        ubgrf_pkg::ADDR_CLK_SELECT: st_next.rdata = st_reg.cks;
        ubgrf_pkg::ADDR_DIVISOR: st_next.rdata = st_reg.divisor;
        ubgrf_pkg::ADDR_STATUS: st_next.rdata = {4'h0, st_reg.rx_busy, st_reg.rx_filt, rx_on, tx_on};
        default: st_next.rdata = 8'h00;
      endcase
    end

    // Transmit divider: half period k base clocks, bit period 2k
    if (!power_on || !tx_on) begin
      st_next.tx_cnt = 8'h00;
      st_next.tx_half = 1'b0;
    end else if (base_tick) begin
      if (st_reg.tx_cnt + 8'h01 >= st_reg.divisor) begin
        st_next.tx_cnt = 8'h00;
        st_next.tx_half = !st_reg.tx_half;
        st_next.tx_tick = st_reg.tx_half;
      end else begin
        st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
      end
    end

    // Receive divider with start detection
    if (!power_on || !rx_on) begin
      st_next.rx_cnt = 8'h00;
      st_next.rx_half = 1'b0;
      st_next.rx_busy = 1'b0;
      st_next.rx_seen_high = 1'b0;
      st_next.rx_verify = 1'b0;
      st_next.rx_bits = 4'h0;
      st_next.rx_prev = 1'b1;
    end else if (base_tick) begin
      st_next.rx_prev = filt_level;
      if (filt_level) begin
        st_next.rx_seen_high = 1'b1;
      end
      if (!st_reg.rx_busy) begin
        if (st_reg.rx_seen_high && st_reg.rx_prev && !filt_level) begin
          st_next.rx_busy = 1'b1;
          st_next.rx_verify = 1'b1;
          st_next.rx_bits = 4'h0;
          st_next.rx_cnt = 8'h00;
          st_next.rx_half = 1'b0;
        end
      end else if (st_reg.rx_cnt + 8'h01 >= st_reg.divisor) begin
        st_next.rx_cnt = 8'h00;
        st_next.rx_half = !st_reg.rx_half;
        if (!st_reg.rx_half) begin
          // Mid-bit sampling point; the first one verifies the start bit
          st_next.rx_tick = 1'b1;
          if (st_reg.rx_verify) begin
            st_next.rx_verify = 1'b0;
            st_next.start_det = !filt_level;
            st_next.rx_busy = !filt_level;
          end else begin
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits + 4'h1 >= frame_len) begin
              // Stop bit sampled: rearm for the next start edge
              st_next.rx_busy = 1'b0;
              st_next.rx_seen_high = 1'b0;
            end
          end
        end
      end else begin
        st_next.rx_cnt = st_reg.rx_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctl0 <= ubgrf_pkg::CONTROL0_RESET;
      st_reg.cks <= ubgrf_pkg::CLK_SELECT_RESET;
      st_reg.divisor <= ubgrf_pkg::DIVISOR_RESET;
      st_reg.rx_prev <= 1'b1;
      st_reg.rx_filt <= 1'b1;
      st_reg.par_present <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = st_reg.rdata;
  assign tx_bit_tick = st_reg.tx_tick;
  assign rx_sample_tick = st_reg.rx_tick;
  assign rx_start_detected = st_reg.start_det;
  assign rx_filtered = st_reg.rx_filt;
  assign parity_bit_present = st_reg.par_present;
  assign parity_check_enable = st_reg.par_check;
  assign parity_tx_force_low = st_reg.par_low;
endmodule : ubgrf_top
`default_nettype wire

// File: ubgrf_top_properties.sv
// Port checker for the baud generator and receive filter
`timescale 1ns/1ps
`default_nettype none
module ubgrf_top_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Receive side and decoded outputs
  input wire logic serial_receive_pin,
  input wire logic tx_bit_tick,
  input wire logic rx_start_detected,
  input wire logic rx_filtered,
  input wire logic parity_bit_present,
  input wire logic parity_check_enable,
  input wire logic parity_tx_force_low
);
  // ******
  // Register shadows and tick spacing
  // ******
  logic [7:0] ctl_reg, cks_reg, div_reg;
  logic [31:0] gap_reg;
  logic seen_reg;
  logic [1:0] par;
  assign par = ctl_reg[3:2];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_reg <= 8'h00;
      cks_reg <= 8'h00;
      div_reg <= 8'hFF;
      seen_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ubgrf_pkg::ADDR_CONTROL0) ctl_reg <= reg_wdata;
      if (reg_wr && reg_addr == ubgrf_pkg::ADDR_CLK_SELECT) cks_reg <= reg_wdata;
      if (reg_wr && reg_addr == ubgrf_pkg::ADDR_DIVISOR) div_reg <= reg_wdata;
      seen_reg <= !reg_wr && (seen_reg || tx_bit_tick);
    end
    gap_reg <= tx_bit_tick ? 32'h1 : gap_reg + 32'h1;
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_div;
    $past(reg_rd) && $past(reg_addr) == ubgrf_pkg::ADDR_DIVISOR |-> reg_rdata == $past(div_reg);
  endproperty
  a_rd_div: assert property (p_rd_div) else $error("divisor readback wrong");
  property p_pwr; (!ctl_reg[7])[*4] |-> !tx_bit_tick; endproperty
  a_pwr: assert property (p_pwr) else $error("tick while unpowered");
  property p_period;
    tx_bit_tick && seen_reg && cks_reg <= 8'h0A |-> gap_reg == 32'(div_reg) << (cks_reg + 8'h01);
  endproperty
  a_period: assert property (p_period) else $error("bit period wrong");
  property p_lag; $changed(rx_filtered) |-> rx_filtered == $past(serial_receive_pin, 3); endproperty
  a_lag: assert property (p_lag) else $error("filter lag wrong");
  property p_start; rx_start_detected |-> !$past(rx_filtered); endproperty
  a_start: assert property (p_start) else $error("start without low");
  property p_zero;
    $stable(ctl_reg) && par == ubgrf_pkg::PARITY_ZERO |-> parity_tx_force_low && !parity_check_enable;
  endproperty
  a_zero: assert property (p_zero) else $error("zero parity decode");
  property p_none;
    $stable(ctl_reg) && par == ubgrf_pkg::PARITY_NONE |-> !parity_bit_present && !parity_check_enable;
  endproperty
  a_none: assert property (p_none) else $error("no parity decode");
endmodule : ubgrf_top_properties
bind ubgrf_top ubgrf_top_properties i_props (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .serial_receive_pin, .tx_bit_tick, .rx_start_detected, .rx_filtered, .parity_bit_present,
  .parity_check_enable, .parity_tx_force_low);
`default_nettype wire
